/* shared/input_cond_pkg.sv */
package input_cond_pkg;

   // ***********************************************************
   // Channel counts
   // ***********************************************************
   localparam int NUM_CONTACT = 20;
   localparam int CONTACT_GROUPS = 5;
   localparam int NUM_LINE = 8;
   localparam int LINE_GROUPS = 2;
   localparam int NUM_VIRT = 4;
   localparam int NUM_PHYS = NUM_CONTACT + NUM_LINE;
   localparam int NUM_CHAN = NUM_PHYS + NUM_VIRT;

   // ***********************************************************
   // Timing
   // ***********************************************************
   localparam int CLK_PERIOD_NS = 5;
   localparam int MS_TICK_NS = 1000000;
   localparam int MS_TICK_CYCLES =
      (MS_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LED_SAVE_MS = 10000;

   // ***********************************************************
   // Register map and fields
   // ***********************************************************
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_SIM = 12'h004;
   localparam logic [11:0] ADDR_FUNC = 12'h008;
   localparam logic [11:0] ADDR_DEB = 12'h00C;
   localparam logic [11:0] ADDR_CFG = 12'h080;
   localparam int CTRL_APP = 0;
   localparam int CTRL_SAVE = 1;
   localparam int CTRL_MAN = 2;
   localparam int CTRL_SEL_LSB = 8;
   localparam int CTRL_W = 13;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 13'h0000;
   localparam int SIM_CH_LSB = 0;
   localparam int SIM_VAL = 8;
   localparam int CFG_EN = 0;
   localparam int CFG_TYPE_LSB = 1;
   localparam int CFG_MODE_LSB = 3;
   localparam int CFG_DEB_LSB = 5;
   localparam int CFG_LED_LSB = 9;
   localparam int CFG_W = 11;
   localparam logic [CFG_W-1:0] CFG_RESET = 11'h260;

   // ***********************************************************
   // Debounce times in ms, selector 3 is the default 50 ms
   // ***********************************************************
   localparam logic [3:0] DEB_SEL_DEFAULT = 4'h3;
   localparam logic [10:0][9:0] DEB_TABLE = {10'h3E8, 10'h2EE,
      10'h1F4, 10'h0FA, 10'h096, 10'h064, 10'h04B, 10'h032,
      10'h028, 10'h01E, 10'h014};

   typedef enum logic [1:0] {DEV_SWITCH, DEV_BUTTON, DEV_CARD} devType_t;
   typedef enum logic [1:0] {PR_CLOSED, PR_OPEN, PR_RISE, PR_FALL} pressMode_t;
   typedef enum logic [1:0] {LED_OFF, LED_ON, LED_INV} ledMode_t;

endpackage

/* rtl/input_signal_conditioner.sv */
// Summary of operation
// - Twenty contact-sense inputs in five groups of four report open or closed.
// - Larger variant adds eight line-voltage sense inputs in two groups.
// - Four virtual inputs take values only from simulate commands.
// - Only enabled channels reach function state and events; disabled ones still debounce and drive their LEDs.
// - Join point follows whichever of physical or simulated changed last.
// - A stage that is not enabled passes its signal through unchanged.
// - Manual status overrides all sources immediately, bypassing delay and lock.
// - By default an LED lights when contact closed or voltage present.
// - Power saving darkens LEDs; any manual button press shows them again.
// - In manual control disabled LEDs operate, inverted LEDs stay inverted.
// - Without loaded application every LED is enabled and non-inverted.
// - LEDs follow the debounce output, or the manual status where one is set, untouched by lock or delay.
// - Debounce time selectable from 20 to 1000 ms, default 50 ms.
// - New level accepted only after stable longer than debounce time.
// - Device type setting picks switch, push button or card holder.
// - Push-button press is closed, open, rising or falling; release complements.
// - Card-inserted is closed, open, rising or falling; removal complements.
// - LED setting is disabled, enabled or inverted, enabled by default.
// - Manual assert button forces selected channel active, clear forces inactive.
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module input_signal_conditioner #(
   parameter int MS_TICK_CYCLES = input_cond_pkg::MS_TICK_CYCLES,
   parameter int LED_SAVE_MS = input_cond_pkg::LED_SAVE_MS,
   parameter bit HAS_LINE = 1'b1
)(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [input_cond_pkg::NUM_CONTACT-1:0] contactIn,
   input wire logic [input_cond_pkg::NUM_LINE-1:0] lineIn,
   input wire logic btnSet,
   input wire logic btnRst,
   input wire logic btnOther,
   output logic [input_cond_pkg::NUM_PHYS-1:0] ledOut,
   output logic [input_cond_pkg::NUM_CHAN-1:0] funcState,
   output logic [input_cond_pkg::NUM_CHAN-1:0] funcEvent,
   output logic manualOn
);

   localparam int NP = input_cond_pkg::NUM_PHYS;
   localparam int NC = input_cond_pkg::NUM_CHAN;
   localparam int CW = input_cond_pkg::CFG_W;

   logic [NP-1:0] sync1_q, sync2_q, rawPrev_q, stable_q, stableSeen_q;
   logic [9:0] debCnt_q [NP];
   logic [17:0] tickCnt_q;
   logic msTick_q;
   logic [2:0] btnSync1_q, btnSync2_q, btnPrev_q;
   logic [2:0] btnRise;
   logic [input_cond_pkg::CTRL_W-1:0] ctrl_q;
   logic [CW-1:0] cfg_q [NC];
   logic [NC-1:0] joinVal_q, ovrMask_q, ovrVal_q, chanVal, funcState_d;
   logic [NC-1:0] funcState_q, funcEvent_q;
   logic [NP-1:0] ledSrc, ledOut_d, ledOut_q;
   logic [15:0] saveCnt_q;
   logic saving_q;
   logic manual, manualOn_q;
   logic [4:0] manSel;
   logic pready_q, pslverr_q, apbDone, apbAccess, simWr, cfgHit, hit;
   logic [31:0] prdata_q, rdata;
   logic [4:0] cfgIdx, simCh;
   logic simVal;

   // ***********************************************************
   // Input synchronisers and millisecond tick
   // ***********************************************************
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
         btnSync1_q <= '0;
         btnSync2_q <= '0;
         btnPrev_q <= '0;
      end
      else
      begin
         sync1_q <= {lineIn & {input_cond_pkg::NUM_LINE{HAS_LINE}},
            contactIn};
         sync2_q <= sync1_q;
         btnSync1_q <= {btnOther, btnRst, btnSet};
         btnSync2_q <= btnSync1_q;
         btnPrev_q <= btnSync2_q;
      end
   end

   assign btnRise = btnSync2_q & ~btnPrev_q;

   // A single tick shared by all channels keeps each counter at ten bits.
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         tickCnt_q <= '0;
         msTick_q <= 1'b0;
      end
      else if (tickCnt_q == 18'(MS_TICK_CYCLES - 1))
      begin
         tickCnt_q <= '0;
         msTick_q <= 1'b1;
      end
      else
      begin
         tickCnt_q <= tickCnt_q + 18'h00001;
         msTick_q <= 1'b0;
      end
   end

   // ***********************************************************
   // Debounce filter
   // ***********************************************************
   // The first tick after a change may come early, so acceptance
   // waits one tick beyond the set time to stay strictly longer.
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         rawPrev_q <= '0;
         stable_q <= '0;
         for (int i = 0; i < NP; i++)
            debCnt_q[i] <= '0;
      end
      else
      begin
         rawPrev_q <= sync2_q;
         for (int i = 0; i < NP; i++)
         begin
            if (sync2_q[i] != rawPrev_q[i] || sync2_q[i] == stable_q[i])
               debCnt_q[i] <= '0;
            else if (msTick_q)
            begin
               if (debCnt_q[i] >= input_cond_pkg::DEB_TABLE[
                     cfg_q[i][input_cond_pkg::CFG_DEB_LSB +: 4]])
               begin
                  stable_q[i] <= sync2_q[i];
                  debCnt_q[i] <= '0;
               end
               else
                  debCnt_q[i] <= debCnt_q[i] + 10'h001;
            end
         end
      end
   end

   // ***********************************************************
   // Join point and manual override
   // ***********************************************************
   assign manual = ctrl_q[input_cond_pkg::CTRL_MAN] &
      ctrl_q[input_cond_pkg::CTRL_APP];
   assign manSel = ctrl_q[input_cond_pkg::CTRL_SEL_LSB +: 5];

   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         joinVal_q <= '0;
         stableSeen_q <= '0;
      end
      else
      begin
         stableSeen_q <= stable_q;
         for (int i = 0; i < NC; i++)
         begin
            if (i < NP && stable_q[i] != stableSeen_q[i])
               joinVal_q[i] <= stable_q[i];
            else if (simWr && simCh == 5'(i))
               joinVal_q[i] <= simVal;
         end
      end
   end

   // The override is kept only for the duration of manual mode.
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         ovrMask_q <= '0;
         ovrVal_q <= '0;
      end
      else if (!manual)
         ovrMask_q <= '0;
      else if (cfg_q[manSel][input_cond_pkg::CFG_EN] &&
            (btnRise[0] || btnRise[1]))
      begin
         ovrMask_q[manSel] <= 1'b1;
         ovrVal_q[manSel] <= btnRise[0];
      end
   end

   assign chanVal = (manual ? ovrMask_q : '0) & ovrVal_q |
      ~(manual ? ovrMask_q : '0) & joinVal_q;

   // ***********************************************************
   // Device-type interpretation
   // ***********************************************************
   // Edge modes act like the matching level, since press and release
   // still alternate one to one on each debounced change.
   always_comb
   begin
      for (int i = 0; i < NC; i++)
      begin
         funcState_d[i] = chanVal[i];
         unique case (input_cond_pkg::devType_t'(
               cfg_q[i][input_cond_pkg::CFG_TYPE_LSB +: 2]))
            input_cond_pkg::DEV_SWITCH: funcState_d[i] = chanVal[i];
            input_cond_pkg::DEV_BUTTON,
            input_cond_pkg::DEV_CARD:
               unique case (input_cond_pkg::pressMode_t'(
                     cfg_q[i][input_cond_pkg::CFG_MODE_LSB +: 2]))
                  input_cond_pkg::PR_CLOSED,
                  input_cond_pkg::PR_RISE:
                     funcState_d[i] = chanVal[i];
                  input_cond_pkg::PR_OPEN,
                  input_cond_pkg::PR_FALL:
                     funcState_d[i] = ~chanVal[i];
               endcase
            default: funcState_d[i] = chanVal[i];
         endcase
         if (!cfg_q[i][input_cond_pkg::CFG_EN])
            funcState_d[i] = 1'b0;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         funcState_q <= '0;
         funcEvent_q <= '0;
         manualOn_q <= 1'b0;
      end
      else
      begin
         funcState_q <= funcState_d;
         funcEvent_q <= funcState_q ^ funcState_d;
         manualOn_q <= manual;
      end
   end

   // ***********************************************************
   // Status LEDs
   // ***********************************************************
   always_ff @(posedge core_clk)
   begin
      if (!rst_b || !ctrl_q[input_cond_pkg::CTRL_SAVE] || |btnRise)
      begin
         saveCnt_q <= '0;
         saving_q <= 1'b0;
      end
      else if (msTick_q && !saving_q)
      begin
         if (saveCnt_q == 16'(LED_SAVE_MS - 1))
            saving_q <= 1'b1;
         saveCnt_q <= saveCnt_q + 16'h0001;
      end
   end

   always_comb
   begin
      for (int i = 0; i < NP; i++)
      begin
         ledSrc[i] = (manual && ovrMask_q[i]) ? ovrVal_q[i] :
            stable_q[i];
         ledOut_d[i] = ledSrc[i];
         if (ctrl_q[input_cond_pkg::CTRL_APP])
            unique case (input_cond_pkg::ledMode_t'(
                  cfg_q[i][input_cond_pkg::CFG_LED_LSB +: 2]))
               input_cond_pkg::LED_OFF:
                  ledOut_d[i] = manual & ledSrc[i];
               input_cond_pkg::LED_ON: ledOut_d[i] = ledSrc[i];
               input_cond_pkg::LED_INV:
                  ledOut_d[i] = ~ledSrc[i];
               default: ledOut_d[i] = ledSrc[i];
            endcase
         if (saving_q)
            ledOut_d[i] = 1'b0;
      end
   end

   // Without an application the setting is ignored.
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
         ledOut_q <= '0;
      else
         ledOut_q <= ledOut_d;
   end

   // ***********************************************************
   // APB slave, one wait state on every access
   // ***********************************************************
   assign apbAccess = psel & penable & ~pready_q;
   assign apbDone = psel & penable & pready_q;
   assign cfgIdx = paddr[6:2];
   assign cfgHit = paddr[11:7] == input_cond_pkg::ADDR_CFG[11:7];
   assign hit = paddr[1:0] == 2'h0 && (cfgHit ||
      paddr == input_cond_pkg::ADDR_CTRL ||
      paddr == input_cond_pkg::ADDR_SIM ||
      paddr == input_cond_pkg::ADDR_FUNC ||
      paddr == input_cond_pkg::ADDR_DEB);
   assign simWr = apbDone & pwrite & (paddr == input_cond_pkg::ADDR_SIM);
   assign simCh = pwdata[input_cond_pkg::SIM_CH_LSB +: 5];
   assign simVal = pwdata[input_cond_pkg::SIM_VAL];

   always_comb
   begin
      rdata = 32'h00000000;
      if (cfgHit && paddr[1:0] == 2'h0)
         rdata = {21'h00000, cfg_q[cfgIdx]};
      else if (paddr == input_cond_pkg::ADDR_CTRL)
         rdata = {19'h00000, ctrl_q};
      else if (paddr == input_cond_pkg::ADDR_FUNC)
         rdata = funcState_q;
      else if (paddr == input_cond_pkg::ADDR_DEB)
         rdata = {4'h0, stable_q};
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
      end
      else
      begin
         pready_q <= apbAccess;
         pslverr_q <= apbAccess & ~hit;
         prdata_q <= (apbAccess && !pwrite) ? rdata : 32'h00000000;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         ctrl_q <= input_cond_pkg::CTRL_RESET;
         for (int i = 0; i < NC; i++)
            cfg_q[i] <= input_cond_pkg::CFG_RESET;
      end
      else if (apbDone && pwrite && hit)
      begin
         if (paddr == input_cond_pkg::ADDR_CTRL)
            ctrl_q <= pwdata[input_cond_pkg::CTRL_W-1:0];
         else if (cfgHit)
            cfg_q[cfgIdx] <= pwdata[CW-1:0];
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign ledOut = ledOut_q;
   assign funcState = funcState_q;
   assign funcEvent = funcEvent_q;
   assign manualOn = manualOn_q;

   // ***********************************************************
   // Checks
   // ***********************************************************
   disEnable_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      !cfg_q[0][input_cond_pkg::CFG_EN] ##1 !cfg_q[0][input_cond_pkg::CFG_EN]
      |-> !funcState_q[0] && !funcEvent_q[0])
      else $error("Disabled channel shows activity.");
   simJoin_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      simWr && simCh == 5'h00 && stable_q[0] == stableSeen_q[0]
      |=> joinVal_q[0] == $past(simVal))
      else $error("Simulated value not taken at join point.");
   manPrio_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      manual && ovrMask_q[1] |-> chanVal[1] == ovrVal_q[1])
      else $error("Manual status did not override.");
   btnForce_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      manual && btnRise == 3'h1 && cfg_q[manSel][input_cond_pkg::CFG_EN]
      |=> ovrMask_q[$past(manSel)] && ovrVal_q[$past(manSel)])
      else $error("Assert button did not force channel active.");
   ledDefault_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      !ctrl_q[input_cond_pkg::CTRL_APP] && !saving_q
      |=> ledOut_q[2] == $past(stable_q[2]))
      else $error("Unloaded LED does not follow input.");
   ledSave_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      saving_q |=> ledOut_q == '0)
      else $error("LED lit while power saving.");
   ledInvert_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      manual && !saving_q && cfg_q[3][input_cond_pkg::CFG_LED_LSB +: 2] ==
      2'h2 |=> ledOut_q[3] == !$past(ledSrc[3]))
      else $error("Inverted LED not inverted in manual mode.");
   debTick_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      $changed(stable_q[0]) |-> $past(msTick_q) && $past(sync2_q[0]) ==
      $past(rawPrev_q[0]))
      else $error("Debounced level changed off tick or unstable.");
   debRestart_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      sync2_q[0] != rawPrev_q[0] |=> debCnt_q[0] == 10'h000)
      else $error("Debounce count not restarted.");
   apbWait_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      apbAccess |=> pready_q ##1 !pready_q)
      else $error("Access not answered after one wait state.");

   simCover_c: cover property (@(posedge core_clk) disable iff (!rst_b)
      simWr ##[1:20] funcEvent_q != '0);
   manCover_c: cover property (@(posedge core_clk) disable iff (!rst_b)
      manual && btnRise[0] ##[1:20] manual && btnRise[1]);
   saveCover_c: cover property (@(posedge core_clk) disable iff (!rst_b)
      saving_q ##1 btnRise != 3'h0);

endmodule

`default_nettype wire

/* testbench/contact_bank.sv */
`timescale 1ns/10ps
`default_nettype none

// *****************************************************
// Contact and line-voltage source model
// *****************************************************
module contact_bank (
   input wire logic core_clk,
   output logic [input_cond_pkg::NUM_CONTACT-1:0] contactIn,
   output logic [input_cond_pkg::NUM_LINE-1:0] lineIn
);
   initial
   begin
      contactIn = '0;
      lineIn = '0;
   end

   task automatic drive(input logic [27:0] v);
      @(posedge core_clk);
      contactIn <= v[19:0];
      lineIn <= v[27:20];
   endtask

   // Real contacts bounce, so a level is offered for n+1 cycles only
   // and then the previous level comes back.
   task automatic glitch(input logic [27:0] v, input int n);
      logic [27:0] keep;
      keep = {lineIn, contactIn};
      drive(v);
      repeat (n) @(posedge core_clk);
      drive(keep);
   endtask
endmodule

`default_nettype wire

/* testbench/tb_input_signal_conditioner.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_input_signal_conditioner;
   localparam int TK = 10;
   localparam logic [11:0] CFG = input_cond_pkg::ADDR_CFG;
   localparam logic [11:0] CTL = input_cond_pkg::ADDR_CTRL;
   logic core_clk;
   logic rst_b;
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [19:0] contactIn;
   logic [7:0] lineIn;
   logic btnSet;
   logic btnRst;
   logic btnOther;
   logic [27:0] ledOut;
   logic [31:0] funcState;
   logic [31:0] funcEvent;
   logic manualOn;
   logic [27:0] ph;
   logic [31:0] rd;
   logic err;
   int n_errors;
   int num_checks;

   input_signal_conditioner #(.MS_TICK_CYCLES(TK), .LED_SAVE_MS(3),
      .HAS_LINE(1'b1)) dut (.core_clk(core_clk), .rst_b(rst_b),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .contactIn(contactIn), .lineIn(lineIn),
      .btnSet(btnSet), .btnRst(btnRst), .btnOther(btnOther),
      .ledOut(ledOut), .funcState(funcState), .funcEvent(funcEvent),
      .manualOn(manualOn));

   contact_bank pins (.core_clk(core_clk), .contactIn(contactIn),
      .lineIn(lineIn));

   // *****************************************************
   // Shared tasks
   // *****************************************************
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk(32'(pready), 32'h1);
   endtask

   function automatic logic [31:0] cfgv(int en, int ty, int md, int db,
      int led);
      return 32'(en + ty * 2 + md * 8 + db * 32 + led * 512);
   endfunction

   task automatic cfgw(input int ch, input logic [31:0] v);
      apb(1'b1, CFG + 12'(ch * 4), v);
   endtask

   task automatic sim(input int ch, input int v);
      apb(1'b1, input_cond_pkg::ADDR_SIM, 32'(ch + v * 256));
   endtask

   task automatic press(input int b);
      @(posedge core_clk);
      btnSet <= (b == 0);
      btnRst <= (b == 1);
      btnOther <= (b == 2);
      wt(4);
      btnSet <= 1'b0;
      btnRst <= 1'b0;
      btnOther <= 1'b0;
      wt(8);
   endtask

   task automatic close_out;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // *****************************************************
   // Scenarios
   // *****************************************************
   task automatic t_reset;
      apb(1'b0, CFG, 32'h0);
      chk(rd, 32'h260);
      apb(1'b0, CTL, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      $display("test reset done");
   endtask

   task automatic t_default;
      ph = 28'h0100001;
      pins.drive(ph);
      wt(50 * TK - 3);
      chk(32'(ledOut), 32'h0);
      wt(2 * TK + 11);
      chk(32'(ledOut), 32'(ph));
      apb(1'b0, input_cond_pkg::ADDR_DEB, 32'h0);
      chk(rd, 32'(ph));
      $display("test default done");
   endtask

   task automatic t_glitch;
      cfgw(1, cfgv(1, 0, 0, 0, 1));
      pins.glitch(ph | 28'h2, 15 * TK);
      wt(25 * TK);
      chk(32'(ledOut[1]), 32'h0);
      ph = ph | 28'h2;
      pins.drive(ph);
      wt(12 * TK);
      pins.glitch(ph & ~28'h2, 3);
      wt(20 * TK - 6);
      chk(32'(ledOut[1]), 32'h0);
      wt(2 * TK + 14);
      chk(32'(ledOut[1]), 32'h1);
      $display("test glitch done");
   endtask

   task automatic t_join;
      apb(1'b1, CTL, 32'h1);
      cfgw(4, cfgv(1, 0, 0, 0, 1));
      cfgw(28, cfgv(1, 0, 0, 0, 0));
      sim(4, 1);
      sim(5, 1);
      sim(28, 1);
      wt(4);
      chk(funcState & 32'h10000030, 32'h10000010);
      wt(25 * TK);
      chk(funcState & 32'h10000030, 32'h10000010);
      ph = ph | 28'h10;
      pins.drive(ph);
      wt(22 * TK + 8);
      ph = ph & ~28'h10;
      pins.drive(ph);
      wt(22 * TK + 8);
      chk(funcState & 32'h30, 32'h0);
      $display("test join done");
   endtask

   task automatic t_modes;
      int ev;
      ev = 0;
      cfgw(6, cfgv(1, 1, 0, 3, 1));
      ph = ph | 28'h40;
      pins.drive(ph);
      wt(52 * TK + 8);
      for (int ty = 1; ty < 3; ty++)
      begin
         for (int md = 0; md < 4; md++)
         begin
            cfgw(6, cfgv(1, ty, md, 3, 1));
            repeat (4)
            begin
               @(posedge core_clk);
               if (funcEvent[6] === 1'b1)
                  ev++;
            end
            chk(32'(funcState[6]), 32'(md % 2 == 0));
         end
      end
      // Seven of the eight mode writes flip the interpreted level.
      chk(32'(ev), 32'h7);
      $display("test modes done");
   endtask

   task automatic t_manual;
      cfgw(2, cfgv(1, 0, 0, 0, 0));
      cfgw(3, cfgv(1, 0, 0, 0, 2));
      wt(4);
      chk(32'(ledOut[3:2]), 32'h2);
      for (int ch = 2; ch < 4; ch++)
      begin
         apb(1'b1, CTL, 32'(5 + ch * 256));
         for (int b = 0; b < 2; b++)
         begin
            press(b);
            chk({ledOut[ch], funcState[ch]},
               {(ch == 2) == (b == 0), b == 0});
         end
         chk(32'(manualOn), 32'h1);
      end
      $display("test manual done");
   endtask

   task automatic t_save;
      apb(1'b1, CTL, 32'h3);
      wt(5 * TK + 8);
      chk(32'(ledOut), 32'h0);
      chk(32'(manualOn), 32'h0);
      press(2);
      chk(32'(ledOut[1]), 32'h1);
      $display("test save done");
   endtask

   // The clock runs free; the watchdog ends a hang well past the
   // few thousand cycles the scenarios need.
   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   initial
   begin
      wt(20000);
      n_errors++;
      close_out;
   end

   initial
   begin
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      btnSet = 1'b0;
      btnRst = 1'b0;
      btnOther = 1'b0;
      n_errors = 0;
      num_checks = 0;
      wt(10);
      rst_b <= 1'b1;
      t_reset;
      t_default;
      t_glitch;
      t_join;
      t_modes;
      t_manual;
      t_save;
      close_out;
   end
endmodule

`default_nettype wire
